// *** rtl/eaw_pkg.sv ***
// What this block does
// - Writing one to soft start launches calculation
// - Busy flag reads one while calculating
// - Sync select zero starts calculation per angle
// - Irq source: timer finish or calculation end
// - Count direction: zero up, one down
// - Phase order: V,W plus or minus 120/240
// - Clock select picks fc/8, /16, /32, /64
// - Modulation select: zero two-phase, one three-phase
// - Transfer enable copies results; waveform enable gates
// - Timer enable runs the angle timer
// - Period is (m + n/16) x 384 clocks
// - Three-phase sine sign flips at 180 degrees
// - Disabling timer stops and clears it
// - Per 16 counts: m+1 clocks n times
// - Angle writes above 17FH are rejected
package eaw_pkg;

   // ------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------
   localparam int          IDX_W        = 14;
   localparam logic [13:0] IDX_CTRL_A   = 14'h1FC0;
   localparam logic [13:0] IDX_CTRL_B   = 14'h1FC1;
   localparam logic [13:0] IDX_PERIOD   = 14'h1FC2;
   localparam logic [13:0] IDX_ANGLE    = 14'h1FC4;
   localparam logic [13:0] IDX_AMP      = 14'h1FC6;
   localparam logic [13:0] IDX_IRQ_STAT = 14'h1FD0;
   localparam logic [13:0] IDX_IRQ_MASK = 14'h1FD1;

   // ------------------------------
   // Field positions and reset values
   // ------------------------------
   localparam int          CB_SOFT_START = 3;
   localparam int          CB_BUSY       = 2;
   localparam int          CB_SYNC_SEL   = 1;
   localparam int          CB_IRQ_SEL    = 0;
   localparam int          IRQ_ANGLE     = 0;
   localparam int          IRQ_WAVEFORM_EN_A      = 1;
   localparam int          IRQ_W         = 2;
   localparam logic [15:0] PERIOD_RST    = 16'h0010;
   localparam logic [11:0] PERIOD_MIN    = 12'h010;
   localparam logic [7:0]  CTRL_A_RST    = 8'h00;
   localparam logic [11:0] AMP_RST       = 12'h000;

   // ------------------------------
   // Angle arithmetic
   // ------------------------------
   localparam int          ANGLE_W     = 9;
   localparam logic [8:0]  ANGLE_MAX   = 9'h17F;
   localparam logic [8:0]  ANGLE_STEPS = 9'h180;
   localparam logic [8:0]  ANGLE_120   = 9'h080;
   localparam logic [8:0]  ANGLE_240   = 9'h100;
   localparam logic [8:0]  ANGLE_HALF  = 9'h0C0;
   localparam int          DIV_EXP_MIN = 3;
   localparam int          DIV_CNT_W   = 6;
   localparam int          PH_LAST     = 2;

   // ------------------------------
   // Types
   // ------------------------------
   typedef struct packed {
      logic       angle_count_dir;
      logic       phase_order_sel;
      logic [1:0] angle_clock_sel;
      logic       modulation_sel;
      logic       result_transfer_en;
      logic       waveform_en_a;
      logic       angle_timer_en;
   } eaw_ctrl_a_t;

   typedef struct packed {
      logic [11:0] u;
      logic [11:0] v;
      logic [11:0] w;
   } eaw_duty_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_WAVEFORM_EN_A,
      ST_DONE
   } eaw_state_t;

endpackage : eaw_pkg

// *** rtl/eaw_clk_div.sv ***
`timescale 1ns/1ps
module eaw_clk_div
   import eaw_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       en_i,
   input  wire logic [1:0] sel_i,
   // Tick out
   output logic            tick_o
);

   logic [DIV_CNT_W-1:0] cnt_q;
   logic [DIV_CNT_W-1:0] cnt_d;
   logic [DIV_CNT_W-1:0] mask;

   // Free-running prescaler, held at zero while disabled
   always_comb
   begin
      cnt_d = en_i ? cnt_q + 6'h01 : 6'h00;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         cnt_q <= 6'h00;
      else
         cnt_q <= cnt_d;
   end

   // One tick every 2^(3+sel) clocks
   always_comb
   begin
      mask   = DIV_CNT_W'((1 << (DIV_EXP_MIN + int'(sel_i))) - 1);
      tick_o = en_i && ((cnt_q & mask) == mask);
   end

endmodule : eaw_clk_div

// *** rtl/eaw_wave_waveform_en_a.sv ***
`timescale 1ns/1ps
module eaw_wave_waveform_en_a
   import eaw_pkg::*;
(
   // Operands
   input  wire logic [7:0]  sine_i,
   input  wire logic [11:0] amp_i,
   input  wire logic [11:0] pwm_period_i,
   input  wire logic [8:0]  angle_i,
   input  wire logic        three_phase_i,
   // Result
   output logic [11:0]      duty_o
);

   logic [19:0] prod;
   logic [11:0] scaled;
   logic [11:0] half_p;
   logic [11:0] half_s;

   // Scaled sine, limited by the PWM period
   always_comb
   begin
      prod   = 20'(sine_i) * 20'(amp_i);
      scaled = prod[19:8];
      if (scaled > pwm_period_i)
         scaled = pwm_period_i;
      half_p = pwm_period_i >> 1;
      half_s = scaled >> 1;
      if (!three_phase_i)
         duty_o = scaled;
      else if (angle_i < ANGLE_HALF)
         duty_o = half_p + half_s;
      else
         duty_o = (half_s > half_p) ? 12'h000 : half_p - half_s;
   end

endmodule : eaw_wave_waveform_en_a

// *** rtl/eaw_angle_wave.sv ***
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module eaw_angle_wave
   import eaw_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Sine table port
   output logic [8:0]       sine_addr_o,
   input  wire logic [7:0]  sine_data_i,
   // PWM generator side
   input  wire logic [11:0] pwm_period_i,
   output eaw_duty_t        duty_o,
   output logic             cmp_we_o,
   // Status and interrupt
   output logic [8:0]       angle_o,
   output logic             waveform_en_a_busy_o,
   output logic             irq_o
);

   // ------------------------------
   // Declarations
   // ------------------------------
   eaw_ctrl_a_t      ctrl_a_q,  ctrl_a_d;
   logic             sync_sel_q, sync_sel_d;
   logic             irq_sel_q, irq_sel_d;
   logic [15:0]      period_q,  period_d;
   logic [11:0]      amp_q,     amp_d;
   logic [IRQ_W-1:0] stat_q,    stat_d;
   logic [IRQ_W-1:0] mask_q,    mask_d;
   logic [31:0]      rdat_q,    rdat_d;
   logic             ack_q,     ack_d;
   logic [12:0]      cnt_q,     cnt_d;
   logic [3:0]       grp_q,     grp_d;
   logic [8:0]       angle_q,   angle_d;
   eaw_state_t       st_q,      st_d;
   logic [1:0]       ph_q,      ph_d;
   logic [8:0]       ph_ang_q,  ph_ang_d;
   eaw_duty_t        res_q,     res_d;
   eaw_duty_t        out_q,     out_d;
   logic             we_q,      we_d;
   logic             busy_q,    busy_d;

   logic             req;
   logic             wr;
   logic [IDX_W-1:0] idx;
   logic [15:0]      wmask;
   logic             tick;
   logic             step;
   logic [11:0]      m_eff;
   logic [12:0]      target;
   logic             soft_start;
   logic             sync_start;
   logic             start;
   logic             waveform_en_a_end;
   logic [11:0]      duty_ph;

   // ------------------------------
   // Helpers
   // ------------------------------

   // Angle offset modulo the 384-step circle
   function automatic logic [8:0] ang_add(input logic [8:0] a,
                                           input logic [8:0] b);
      logic [9:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, ANGLE_STEPS})
         s = s - {1'b0, ANGLE_STEPS};
      return s[8:0];
   endfunction : ang_add

   // Angle of phase p relative to U
   function automatic logic [8:0] ph_angle(input logic [8:0] u,
                                            input logic [1:0] p,
                                            input logic       minus);
      logic [8:0] off;
      off = 9'h000;
      if (p == 2'h1)
         off = minus ? ANGLE_240 : ANGLE_120;
      else if (p == 2'h2)
         off = minus ? ANGLE_120 : ANGLE_240;
      return ang_add(u, off);
   endfunction : ph_angle

   // ------------------------------
   // Bus decode
   // ------------------------------

   // Byte lanes to bit mask, address index
   always_comb
   begin
      req   = wb_cyc_i && wb_stb_i && !ack_q;
      wr    = req && wb_we_i;
      idx   = wb_adr_i[15:2];
      wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   end

   // ------------------------------
   // Register file
   // ------------------------------

   // Next values of software registers and ack
   always_comb
   begin
      ctrl_a_d   = ctrl_a_q;
      sync_sel_d = sync_sel_q;
      irq_sel_d  = irq_sel_q;
      period_d   = period_q;
      amp_d      = amp_q;
      mask_d     = mask_q;
      soft_start = 1'b0;
      ack_d      = req;
      if (wr)
      begin
         case (idx)
            IDX_CTRL_A:
               if (wb_sel_i[0])
                  ctrl_a_d = eaw_ctrl_a_t'(wb_dat_i[7:0]);
            IDX_CTRL_B:
               if (wb_sel_i[0])
               begin
                  sync_sel_d = wb_dat_i[CB_SYNC_SEL];
                  irq_sel_d  = wb_dat_i[CB_IRQ_SEL];
                  soft_start = wb_dat_i[CB_SOFT_START];
               end
            IDX_PERIOD:
               period_d = (period_q & ~wmask) | (wb_dat_i[15:0] & wmask);
            IDX_AMP:
               amp_d = (amp_q & ~wmask[11:0])
                     | (wb_dat_i[11:0] & wmask[11:0]);
            IDX_IRQ_MASK:
               if (wb_sel_i[0])
                  mask_d = wb_dat_i[IRQ_W-1:0];
            default:
               ;
         endcase
      end
   end

   // Read data; bit 3 of control B always reads zero
   always_comb
   begin
      rdat_d = 32'h0000_0000;
      if (req && !wb_we_i)
      begin
         case (idx)
            IDX_CTRL_A:   rdat_d[7:0] = ctrl_a_q;
            IDX_CTRL_B:
            begin
               rdat_d[CB_BUSY]     = busy_q;
               rdat_d[CB_SYNC_SEL] = sync_sel_q;
               rdat_d[CB_IRQ_SEL]  = irq_sel_q;
            end
            IDX_PERIOD:   rdat_d[15:0] = period_q;
            IDX_ANGLE:    rdat_d[8:0]  = angle_q;
            IDX_AMP:      rdat_d[11:0] = amp_q;
            IDX_IRQ_STAT: rdat_d[IRQ_W-1:0] = stat_q;
            IDX_IRQ_MASK: rdat_d[IRQ_W-1:0] = mask_q;
            default:      rdat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_a_q   <= eaw_ctrl_a_t'(CTRL_A_RST);
         sync_sel_q <= 1'b0;
         irq_sel_q  <= 1'b0;
         period_q   <= PERIOD_RST;
         amp_q      <= AMP_RST;
         mask_q     <= '0;
         rdat_q     <= 32'h0000_0000;
         ack_q      <= 1'b0;
      end
      else
      begin
         ctrl_a_q   <= ctrl_a_d;
         sync_sel_q <= sync_sel_d;
         irq_sel_q  <= irq_sel_d;
         period_q   <= period_d;
         amp_q      <= amp_d;
         mask_q     <= mask_d;
         rdat_q     <= rdat_d;
         ack_q      <= ack_d;
      end
   end

   // ------------------------------
   // Electrical angle timer
   // ------------------------------

   eaw_clk_div u_div (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .en_i    (ctrl_a_q.angle_timer_en),
      .sel_i   (ctrl_a_q.angle_clock_sel),
      .tick_o  (tick)
   );

   // Period target: m for the first n of 16 counts, m-1 for the rest
   always_comb
   begin
      m_eff  = (period_q[11:0] < PERIOD_MIN) ? PERIOD_MIN : period_q[11:0];
      target = (grp_q < period_q[15:12]) ? {1'b0, m_eff}
                                         : {1'b0, m_eff} - 13'h0001;
      step   = tick && (cnt_q == target);
   end

   // Counter, group position and angle
   always_comb
   begin
      cnt_d   = cnt_q;
      grp_d   = grp_q;
      angle_d = angle_q;
      if (!ctrl_a_q.angle_timer_en)
      begin
         cnt_d = 13'h0000;
         grp_d = 4'h0;
      end
      else if (step)
      begin
         cnt_d = 13'h0000;
         grp_d = grp_q + 4'h1;
         if (!ctrl_a_q.angle_count_dir)
            angle_d = ang_add(angle_q, 9'h001);
         else
            angle_d = ang_add(angle_q, ANGLE_MAX);
      end
      else if (tick)
         cnt_d = cnt_q + 13'h0001;
      // Software write wins, out of range values ignored
      if (wr && idx == IDX_ANGLE && (wb_sel_i[0] || wb_sel_i[1]))
      begin
         if (((angle_q & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]))
             <= ANGLE_MAX)
            angle_d = (angle_q & ~wmask[8:0])
                    | (wb_dat_i[8:0] & wmask[8:0]);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q   <= 13'h0000;
         grp_q   <= 4'h0;
         angle_q <= 9'h000;
      end
      else
      begin
         cnt_q   <= cnt_d;
         grp_q   <= grp_d;
         angle_q <= angle_d;
      end
   end

   // ------------------------------
   // Waveform arithmetic sequencer
   // ------------------------------

   // Start sources, gated by the waveform enable
   always_comb
   begin
      sync_start = step && !sync_sel_q;
      start      = ctrl_a_q.waveform_en_a
                 && (soft_start || sync_start);
   end

   eaw_wave_waveform_en_a u_waveform_en_a (
      .sine_i        (sine_data_i),
      .amp_i         (amp_q),
      .pwm_period_i  (pwm_period_i),
      .angle_i       (ph_ang_q),
      .three_phase_i (ctrl_a_q.modulation_sel),
      .duty_o        (duty_ph)
   );

   // Three phases: present address, then take the product
   always_comb
   begin
      st_d     = st_q;
      ph_d     = ph_q;
      ph_ang_d = ph_ang_q;
      res_d    = res_q;
      out_d    = out_q;
      we_d     = 1'b0;
      busy_d   = busy_q;
      waveform_en_a_end = 1'b0;
      case (st_q)
         ST_IDLE:
            if (start)
            begin
               busy_d   = 1'b1;
               ph_d     = 2'h0;
               ph_ang_d = angle_q;
               st_d     = ST_ADDR;
            end
         ST_ADDR:
            st_d = ST_WAVEFORM_EN_A;
         ST_WAVEFORM_EN_A:
         begin
            case (ph_q)
               2'h0:    res_d.u = duty_ph;
               2'h1:    res_d.v = duty_ph;
               default: res_d.w = duty_ph;
            endcase
            if (ph_q == 2'(PH_LAST))
               st_d = ST_DONE;
            else
            begin
               ph_d     = ph_q + 2'h1;
               ph_ang_d = ph_angle(angle_q, ph_q + 2'h1,
                                   ctrl_a_q.phase_order_sel);
               st_d     = ST_ADDR;
            end
         end
         ST_DONE:
         begin
            if (ctrl_a_q.result_transfer_en)
            begin
               out_d = res_q;
               we_d  = 1'b1;
            end
            busy_d   = 1'b0;
            waveform_en_a_end = 1'b1;
            st_d     = ST_IDLE;
         end
         default:
            st_d = ST_IDLE;
      endcase
      if (!ctrl_a_q.waveform_en_a)
      begin
         st_d   = ST_IDLE;
         busy_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q     <= ST_IDLE;
         ph_q     <= 2'h0;
         ph_ang_q <= 9'h000;
         res_q    <= '0;
         out_q    <= '0;
         we_q     <= 1'b0;
         busy_q   <= 1'b0;
      end
      else
      begin
         st_q     <= st_d;
         ph_q     <= ph_d;
         ph_ang_q <= ph_ang_d;
         res_q    <= res_d;
         out_q    <= out_d;
         we_q     <= we_d;
         busy_q   <= busy_d;
      end
   end

   // ------------------------------
   // Interrupt status
   // ------------------------------

   // Sticky events; a new event wins over write-one-to-clear
   always_comb
   begin
      stat_d = stat_q;
      if (wr && idx == IDX_IRQ_STAT && wb_sel_i[0])
         stat_d = stat_q & ~wb_dat_i[IRQ_W-1:0];
      if (irq_sel_q ? waveform_en_a_end : step)
         stat_d[IRQ_ANGLE] = 1'b1;
      if (waveform_en_a_end)
         stat_d[IRQ_WAVEFORM_EN_A] = 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         stat_q <= '0;
      else
         stat_q <= stat_d;
   end

   // ------------------------------
   // Outputs
   // ------------------------------
   assign wb_dat_o    = rdat_q;
   assign wb_ack_o    = ack_q;
   assign sine_addr_o = ph_ang_q;
   assign duty_o      = out_q;
   assign cmp_we_o    = we_q;
   assign angle_o     = angle_q;
   assign waveform_en_a_busy_o = busy_q;
   assign irq_o       = |(stat_q & mask_q);

endmodule : eaw_angle_wave

// *** verif/eaw_angle_wave_assertions.sv ***
`timescale 1ns/1ps
module eaw_angle_wave_assertions
   import eaw_pkg::*;
(
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Datapath
   input wire logic [8:0]  sine_addr_o,
   input wire logic [11:0] pwm_period_i,
   input wire eaw_duty_t   duty_o,
   input wire logic        cmp_we_o,
   input wire logic [8:0]  angle_o,
   input wire logic        waveform_en_a_busy_o,
   input wire logic        irq_o
);
   // ------------------------------
   // Bus, angle and calculation checks
   // ------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_ack_after_req: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_angle_in_range: assert property (angle_o <= ANGLE_MAX)
      else $error("angle beyond last step");
   // One neighbour step, up or down, when no write lands
   chk_angle_one_step: assert property (
      ($changed(angle_o) && !wb_ack_o) |->
         ((10'(angle_o) + 10'h180 - 10'($past(angle_o))) % 10'h180)
            inside {10'h001, 10'h17F})
      else $error("angle jumped");
   chk_busy_span: assert property (
      $rose(waveform_en_a_busy_o) |-> waveform_en_a_busy_o [*7] ##1 !waveform_en_a_busy_o)
      else $error("busy span wrong");
   chk_cmp_at_end: assert property (cmp_we_o |-> $fell(waveform_en_a_busy_o))
      else $error("transfer not at calculation end");
   chk_cmp_one_pulse: assert property (cmp_we_o |=> !cmp_we_o)
      else $error("transfer pulse too long");
   chk_duty_held: assert property (!cmp_we_o |-> $stable(duty_o))
      else $error("duty moved without transfer");
   chk_duty_capped: assert property (
      cmp_we_o |-> duty_o.u <= pwm_period_i && duty_o.v <= pwm_period_i
                   && duty_o.w <= pwm_period_i)
      else $error("duty above period");
   chk_sine_addr_range: assert property (sine_addr_o <= ANGLE_MAX)
      else $error("sine address beyond table");

   // Main scenarios
   cov_transfer: cover property (cmp_we_o);
   cov_irq_rise: cover property ($rose(irq_o));
   cov_wrap_up: cover property (angle_o == ANGLE_MAX ##1 angle_o == 9'h000);
endmodule : eaw_angle_wave_assertions

bind eaw_angle_wave eaw_angle_wave_assertions chk_u (.clk_i, .rst_n_i,
   .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sine_addr_o,
   .pwm_period_i, .duty_o, .cmp_we_o, .angle_o, .waveform_en_a_busy_o, .irq_o);

// *** verif/eaw_pwm_model.sv ***
`timescale 1ns/1ps
module eaw_pwm_model
   import eaw_pkg::*;
#(
   parameter logic [11:0] PERIOD = 12'h3FF
)
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Block side
   input  wire logic [8:0] sine_addr_i,
   input  wire eaw_duty_t  duty_i,
   input  wire logic       cmp_we_i,
   output logic [7:0]      sine_data_o,
   output logic [11:0]     pwm_period_o,
   // Observation
   output eaw_duty_t       cmp_o,
   output logic [7:0]      cnt_o
);
   // ------------------------------
   // Sine table and compare registers
   // ------------------------------
   // Half the address, stable while the address is held
   assign sine_data_o  = sine_addr_i[8:1];
   assign pwm_period_o = PERIOD;

   // Compare registers load on each transfer pulse
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cmp_o <= '0;
         cnt_o <= 8'h00;
      end
      else if (cmp_we_i)
      begin
         cmp_o <= duty_i;
         cnt_o <= cnt_o + 8'h01;
      end
   end
endmodule : eaw_pwm_model

// *** verif/electrical_angle_waveform_waveform_en_a_bench.sv ***
`timescale 1ns/1ps
module electrical_angle_waveform_waveform_en_a_bench
   import eaw_pkg::*;
;
   // ------------------------------
   // Signals and instances
   // ------------------------------
   localparam logic [11:0] AMPV = 12'h180;
   localparam logic [11:0] PER  = 12'h3FF;
   localparam logic [13:0] RIX [8] = '{IDX_CTRL_A, IDX_CTRL_B,
      IDX_PERIOD, IDX_ANGLE, IDX_AMP, IDX_IRQ_STAT, IDX_IRQ_MASK, 14'h1FC8};
   logic        clk_i;
   logic        rst_n_i = 1'b0;
   logic        wb_cyc  = 1'b0;
   logic        wb_we   = 1'b0;
   logic [15:0] wb_adr  = 16'h0;
   logic [31:0] wb_dat  = 32'h0;
   logic [31:0] wb_q;
   logic        ack;
   logic [8:0]  sadr;
   logic [7:0]  sdat;
   logic [11:0] per;
   eaw_duty_t   duty;
   eaw_duty_t   cmp;
   logic        we;
   logic [8:0]  angle;
   logic [7:0]  cnt;
   logic        irq;
   int          failures = 0;
   int          tests_run = 0;
   int          cycles = 0;

   eaw_angle_wave dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_q), .wb_ack_o(ack), .sine_addr_o(sadr),
      .sine_data_i(sdat), .pwm_period_i(per), .duty_o(duty),
      .cmp_we_o(we), .angle_o(angle), .waveform_en_a_busy_o(), .irq_o(irq));
   eaw_pwm_model #(.PERIOD(PER)) pwm_u (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .sine_addr_i(sadr), .duty_i(duty),
      .cmp_we_i(we), .sine_data_o(sdat), .pwm_period_o(per),
      .cmp_o(cmp), .cnt_o(cnt));

   // ------------------------------
   // Tasks and expectations
   // ------------------------------
   task automatic acc(input logic w, input logic [13:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_we  <= w;
      wb_adr <= {a, 2'b00};
      wb_dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = wb_q;
      wb_cyc <= 1'b0;
      wb_we  <= 1'b0;
   endtask : acc

   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [13:0] a, output logic [31:0] q);
      acc(1'b0, a, 32'h0, q);
   endtask : rd

   task automatic check(input string n, input logic [31:0] e,
                        input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : check

   // Waits for one step, then times n further steps
   task automatic gap(input int n, output int c);
      logic [8:0] p;
      p = angle;
      c = 0;
      while (angle === p) @(posedge clk_i);
      for (int k = 0; k < n; k++)
      begin
         p = angle;
         do begin @(posedge clk_i); c++; end while (angle === p);
      end
   endtask : gap

   task automatic wait_cnt(input logic [7:0] c);
      while (cnt === c) @(posedge clk_i);
   endtask : wait_cnt

   function automatic logic [8:0] pa(input logic [8:0] a,
                                     input logic [8:0] d);
      logic [9:0] x;
      x = {1'b0, a} + {1'b0, d};
      if (x >= 10'h180) x = x - 10'h180;
      pa = x[8:0];
   endfunction : pa

   function automatic logic [11:0] ed(input logic [8:0] a,
                                      input logic th);
      logic [19:0] s;
      logic [11:0] h;
      logic [11:0] q;
      s = ({12'h0, a[8:1]} * {8'h0, AMPV}) >> 8;
      if (s > {8'h0, PER}) s = {8'h0, PER};
      h = {1'b0, PER[11:1]};
      q = {1'b0, s[11:1]};
      ed = !th ? s[11:0] : (a < ANGLE_HALF) ? h + q
         : (h > q) ? h - q : 12'h000;
   endfunction : ed

   task automatic report_and_stop;
      if (failures == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Cuts a hung run short
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failures++;
         report_and_stop;
      end
   end

   // ------------------------------
   // Scenarios
   // ------------------------------
   initial
   begin
      logic [31:0] r;
      logic [31:0] t;
      logic [8:0]  u;
      logic [8:0]  v;
      logic [8:0]  w;
      logic [7:0]  c;
      int          n;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // Reset values, unmapped place last
      for (int i = 0; i < 8; i++)
      begin
         rd(RIX[i], r);
         check("reset_value", (RIX[i] == IDX_PERIOD) ?
               {16'h0, PERIOD_RST} : 32'h0, r);
      end
      wr(IDX_ANGLE, 32'h17F);
      wr(IDX_ANGLE, 32'h180);
      rd(IDX_ANGLE, r);
      check("angle_limit", 32'h17F, r);
      wr(IDX_AMP, {20'h0, AMPV});
      // Soft start in each phase order and modulation
      for (int i = 0; i < 4; i++)
      begin
         u = 9'h150;
         v = pa(u, i[0] ? ANGLE_240 : ANGLE_120);
         w = pa(u, i[0] ? ANGLE_120 : ANGLE_240);
         wr(IDX_ANGLE, {23'h0, u});
         wr(IDX_CTRL_A, {25'h0, i[0], 2'b00, i[1], 3'b110});
         c = cnt;
         wr(IDX_CTRL_B, 32'h0A);
         rd(IDX_CTRL_B, r);
         check("busy", 32'h06, r);
         wait_cnt(c);
         rd(IDX_CTRL_B, r);
         check("idle", 32'h02, r);
         check("duty_u", {20'h0, ed(u, i[1])}, {20'h0, cmp.u});
         check("duty_v", {20'h0, ed(v, i[1])}, {20'h0, cmp.v});
         check("duty_w", {20'h0, ed(w, i[1])}, {20'h0, cmp.w});
      end
      // Transfer off, then waveform off
      c = cnt;
      wr(IDX_CTRL_A, 32'h02);
      wr(IDX_CTRL_B, 32'h0A);
      repeat (20) @(posedge clk_i);
      check("no_transfer", {24'h0, c}, {24'h0, cnt});
      wr(IDX_CTRL_A, 32'h00);
      wr(IDX_CTRL_B, 32'h0A);
      rd(IDX_CTRL_B, r);
      check("no_waveform_en_a", 32'h02, r);
      // Step time per clock select, timer stopped for each change
      for (int s = 0; s < 4; s++)
      begin
         wr(IDX_CTRL_A, {26'h0, s[1:0], 4'h0});
         wr(IDX_CTRL_A, {26'h0, s[1:0], 4'h1});
         gap(1, n);
         check("step_time", 32'd128 << s, n);
         wr(IDX_CTRL_A, {26'h0, s[1:0], 4'h0});
      end
      wr(IDX_CTRL_A, 32'h00);
      wr(IDX_PERIOD, 32'h4010);
      wr(IDX_CTRL_A, 32'h01);
      gap(16, n);
      check("group_time", 32'd2080, n);
      wr(IDX_CTRL_A, 32'h00);
      rd(IDX_ANGLE, r);
      repeat (300) @(posedge clk_i);
      rd(IDX_ANGLE, t);
      check("stopped", r, t);
      // Down through zero, up through the last step
      wr(IDX_CTRL_A, 32'h80);
      wr(IDX_ANGLE, 32'h0);
      wr(IDX_CTRL_A, 32'h81);
      gap(0, n);
      check("down_wrap", 32'h17F, {23'h0, angle});
      wr(IDX_CTRL_A, 32'h00);
      wr(IDX_ANGLE, 32'h17F);
      wr(IDX_CTRL_A, 32'h01);
      gap(0, n);
      check("up_wrap", 32'h0, {23'h0, angle});
      // Angle-synchronous start on, then off
      wr(IDX_CTRL_B, 32'h00);
      c = cnt;
      wr(IDX_CTRL_A, 32'h07);
      wait_cnt(c);
      check("sync_on", {24'h0, c + 8'h01}, {24'h0, cnt});
      wr(IDX_CTRL_B, 32'h02);
      repeat (20) @(posedge clk_i);
      c = cnt;
      repeat (300) @(posedge clk_i);
      check("sync_off", {24'h0, c}, {24'h0, cnt});
      // Interrupt from angle step: set, masked, cleared
      wr(IDX_IRQ_STAT, 32'h3);
      wr(IDX_IRQ_MASK, 32'h1);
      gap(0, n);
      wr(IDX_CTRL_A, 32'h00);
      rd(IDX_IRQ_STAT, r);
      check("irq_step", 32'h1, r);
      check("irq_on", 32'h1, {31'h0, irq});
      wr(IDX_IRQ_MASK, 32'h0);
      check("irq_masked", 32'h0, {31'h0, irq});
      wr(IDX_IRQ_MASK, 32'h3);
      wr(IDX_IRQ_STAT, 32'h1);
      check("irq_cleared", 32'h0, {31'h0, irq});
      // Interrupt from calculation end
      wr(IDX_CTRL_A, 32'h06);
      c = cnt;
      wr(IDX_CTRL_B, 32'h0B);
      wait_cnt(c);
      rd(IDX_IRQ_STAT, r);
      check("irq_waveform_en_a", 32'h3, r);
      check("irq_waveform_en_a_on", 32'h1, {31'h0, irq});
      report_and_stop;
   end
endmodule : electrical_angle_waveform_waveform_en_a_bench
